/* File: rtl/uis_pkg.sv */
// Package with register map, field positions and reset values for the interrupt status block
package uis_pkg;
    localparam logic [7:0] ADDR_ISR = 8'h1C;
    localparam logic [7:0] ADDR_FSR = 8'h18;
    localparam logic [7:0] ADDR_MSR = 8'h14;
    localparam logic [7:0] ADDR_IER = 8'h04;
    localparam logic [7:0] ADDR_RBR = 8'h00;
    localparam logic [7:0] ADDR_THR = 8'h00;
    localparam logic [7:0] ADDR_TOR = 8'h20;
    localparam logic [7:0] ADDR_CFG = 8'h40;
    // Status register fields
    localparam int ISR_DMA_OVR_IND = 29;
    localparam int ISR_DMA_IDLE_IND = 28;
    localparam int ISR_DMA_CTS_IND = 27;
    localparam int ISR_DMA_LERR_IND = 26;
    localparam int ISR_DMA_OVR_FLAG = 21;
    localparam int ISR_DMA_IDLE_FLAG = 20;
    localparam int ISR_DMA_CTS_FLAG = 19;
    localparam int ISR_DMA_LERR_FLAG = 18;
    localparam int ISR_OVR_IND = 13;
    localparam int ISR_IDLE_IND = 12;
    localparam int ISR_CTS_IND = 11;
    localparam int ISR_LERR_IND = 10;
    localparam int ISR_TXD_IND = 9;
    localparam int ISR_RXL_IND = 8;
    localparam int ISR_OVR_FLAG = 5;
    localparam int ISR_IDLE_FLAG = 4;
    localparam int ISR_CTS_FLAG = 3;
    localparam int ISR_LERR_FLAG = 2;
    localparam int ISR_TXD_FLAG = 1;
    localparam int ISR_RXL_FLAG = 0;
    // FIFO status and modem status fields
    localparam int FSR_TX_OVER = 24;
    localparam int FSR_BREAK = 6;
    localparam int FSR_FRAME = 5;
    localparam int FSR_PARITY = 4;
    localparam int FSR_ADDR = 3;
    localparam int FSR_RX_OVER = 0;
    localparam int MSR_CTS_TOG = 0;
    // Enable register fields
    localparam int IER_RXL = 0;
    localparam int IER_TXD = 1;
    localparam int IER_LERR = 2;
    localparam int IER_CTS = 3;
    localparam int IER_IDLE = 4;
    localparam int IER_OVR = 5;
    localparam int IER_DMA_TXD = 6;
    localparam int IER_DMA_RXL = 7;
    // Config register fields and reset values
    localparam int CFG_DMA = 0;
    localparam int CFG_RS485 = 1;
    localparam int CFG_TRIG_LSB = 8;
    localparam logic [31:0] IER_RESET = 32'h0000_0000;
    localparam logic [7:0] TRIG_RESET = 8'h01;
    localparam logic [7:0] IDLE_CMP_RESET = 8'h00;
endpackage

/* File: rtl/uis_core.sv */
// Interrupt flag and indicator logic of a serial port with an APB register slave
`timescale 1ns/1ns
// What this block does
// - DMA overrun indicator is overrun enable AND DMA overrun flag
// - DMA receive-idle indicator is idle enable AND DMA idle flag
// - DMA CTS-change indicator is CTS enable AND DMA CTS flag
// - DMA line-error indicator is line-error enable AND DMA line-error flag
// - Software overrun and receive-idle indicators are enable AND flag
// - Software CTS-change and line-error indicators are enable AND flag
// - Receive-level indicator is receive-level enable AND flag
// - Transmit-drained indicator is enable AND flag, DMA copy in DMA mode
// - Overrun flag follows OR of transmit and receive overflow flags, DMA copy in DMA mode
// - Idle flag sets when FIFO holds data, quiet, counter hits a nonzero compare
// - Reading the receive buffer clears the idle flag
// - CTS-change flag follows the CTS toggled bit, cleared by write one
// - Line-error flag follows OR of break, framing, parity flags
// - In RS-485 mode the address byte flag also sets line error
// - Drained flag sets on last byte to shifter, clears on holding write
// - Receive-level flag sets when FIFO count equals trigger level
// - Receive-level flag clears when count drops below trigger level
// - DMA mode drives six hardware indicators toward interrupt controller
// - CTS toggled bit sets on CTS change, cleared by write one
// - Transmit overflow sets on holding write while FIFO full
module uis_core #(
    parameter int CNT_W = 7
) (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic clk_en_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic cts_in,
    input wire logic rx_overflow_in,
    input wire logic break_in,
    input wire logic framing_in,
    input wire logic parity_in,
    input wire logic addr_byte_in,
    input wire logic tx_full_in,
    input wire logic tx_last_shift_in,
    input wire logic rx_push_in,
    input wire logic [CNT_W-1:0] rx_count_in,
    input wire logic idle_tick_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic irq_out,
    output logic [5:0] dma_ind_out,
    output logic rx_pop_out,
    output logic tx_push_out
);
    import uis_pkg::*;

    logic [31:0] ier;
    logic [7:0] idle_cmp;
    logic [7:0] trig;
    logic dma_mode, rs485_mode;
    logic tx_over, rx_over, brk, frm, par, adrf;
    logic cts_tog, cts_q, cts_seen;
    logic idle_flag, txd_flag, rxl_flag;
    logic [7:0] idle_cnt;
    logic [31:0] isr;

    // APB decode
    wire acc = psel_in & penable_in;
    wire wr = acc & pwrite_in;
    wire rd = acc & ~pwrite_in;
    wire wr_fsr = wr & (paddr_in == ADDR_FSR);
    wire wr_msr = wr & (paddr_in == ADDR_MSR);
    wire wr_thr = wr & (paddr_in == ADDR_THR);
    wire rd_rbr = rd & (paddr_in == ADDR_RBR);
    wire mapped = (paddr_in == ADDR_ISR) | (paddr_in == ADDR_FSR) | (paddr_in == ADDR_MSR) |
                  (paddr_in == ADDR_IER) | (paddr_in == ADDR_RBR) | (paddr_in == ADDR_TOR) |
                  (paddr_in == ADDR_CFG);

    // Combined flags
    wire ovr_flag = tx_over | rx_over;
    wire lerr_flag = brk | frm | par | (rs485_mode & adrf);
    wire cts_flag = cts_tog;
    wire [CNT_W-1:0] trig_c = trig[CNT_W-1:0];
    wire rx_empty = (rx_count_in == '0);

    // Indicators
    wire ind_ovr = ier[IER_OVR] & ovr_flag;
    wire ind_idle = ier[IER_IDLE] & idle_flag;
    wire ind_cts = ier[IER_CTS] & cts_flag;
    wire ind_lerr = ier[IER_LERR] & lerr_flag;
    wire ind_txd = ier[IER_TXD] & txd_flag;
    wire ind_rxl = ier[IER_RXL] & rxl_flag;
    wire [5:0] next_dma_ind = dma_mode ? {ind_ovr, ind_idle, ind_cts, ind_lerr, ind_txd, ind_rxl} : 6'h00;
    wire next_irq = |{ind_ovr, ind_idle, ind_cts, ind_lerr, ind_txd, ind_rxl};

    // Status word, reserved bits zero
    always_comb begin
        isr = 32'h0000_0000;
        isr[ISR_DMA_OVR_IND] = dma_mode & ind_ovr;
        isr[ISR_DMA_IDLE_IND] = dma_mode & ind_idle;
        isr[ISR_DMA_CTS_IND] = dma_mode & ind_cts;
        isr[ISR_DMA_LERR_IND] = dma_mode & ind_lerr;
        isr[ISR_DMA_OVR_FLAG] = dma_mode & ovr_flag;
        isr[ISR_DMA_IDLE_FLAG] = dma_mode & idle_flag;
        isr[ISR_DMA_CTS_FLAG] = dma_mode & cts_flag;
        isr[ISR_DMA_LERR_FLAG] = dma_mode & lerr_flag;
        isr[ISR_OVR_IND] = ind_ovr;
        isr[ISR_IDLE_IND] = ind_idle;
        isr[ISR_CTS_IND] = ind_cts;
        isr[ISR_LERR_IND] = ind_lerr;
        isr[ISR_TXD_IND] = ind_txd;
        isr[ISR_RXL_IND] = ind_rxl;
        isr[ISR_OVR_FLAG] = ovr_flag;
        isr[ISR_IDLE_FLAG] = idle_flag;
        isr[ISR_CTS_FLAG] = cts_flag;
        isr[ISR_LERR_FLAG] = lerr_flag;
        isr[ISR_TXD_FLAG] = txd_flag;
        isr[ISR_RXL_FLAG] = rxl_flag;
    end

    // Read mux
    logic [31:0] rdata;
    always_comb begin
        rdata = 32'h0000_0000;
        case (paddr_in)
            ADDR_ISR: rdata = isr;
            ADDR_FSR: rdata = {7'h00, tx_over, 17'h0_0000, brk, frm, par, adrf, 2'h0, rx_over};
            ADDR_MSR: rdata = {31'h0000_0000, cts_tog};
            ADDR_IER: rdata = ier;
            ADDR_TOR: rdata = {24'h00_0000, idle_cmp};
            ADDR_CFG: rdata = {16'h0000, trig, 6'h00, rs485_mode, dma_mode};
            default: rdata = 32'h0000_0000;
        endcase
    end

    // Control registers written by software
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            ier <= IER_RESET;
            idle_cmp <= IDLE_CMP_RESET;
            trig <= TRIG_RESET;
            dma_mode <= 1'b0;
            rs485_mode <= 1'b0;
        end else if (clk_en_in && wr) begin
            if (paddr_in == ADDR_IER) ier <= pwdata_in;
            if (paddr_in == ADDR_TOR) idle_cmp <= pwdata_in[7:0];
            if (paddr_in == ADDR_CFG) begin
                dma_mode <= pwdata_in[CFG_DMA];
                rs485_mode <= pwdata_in[CFG_RS485];
                trig <= pwdata_in[CFG_TRIG_LSB +: 8];
            end
        end
    end

    // Sticky source flags, set wins over write-one clear
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            tx_over <= 1'b0;
            rx_over <= 1'b0;
            brk <= 1'b0;
            frm <= 1'b0;
            par <= 1'b0;
            adrf <= 1'b0;
            cts_tog <= 1'b0;
            cts_q <= 1'b0;
            cts_seen <= 1'b0;
        end else if (clk_en_in) begin
            tx_over <= (wr_thr & tx_full_in) | (tx_over & ~(wr_fsr & pwdata_in[FSR_TX_OVER]));
            rx_over <= rx_overflow_in | (rx_over & ~(wr_fsr & pwdata_in[FSR_RX_OVER]));
            brk <= break_in | (brk & ~(wr_fsr & pwdata_in[FSR_BREAK]));
            frm <= framing_in | (frm & ~(wr_fsr & pwdata_in[FSR_FRAME]));
            par <= parity_in | (par & ~(wr_fsr & pwdata_in[FSR_PARITY]));
            adrf <= (rs485_mode & addr_byte_in) | (adrf & ~(wr_fsr & pwdata_in[FSR_ADDR]));
            cts_q <= cts_in;
            cts_seen <= 1'b1;
            cts_tog <= (cts_seen & (cts_q != cts_in)) | (cts_tog & ~(wr_msr & pwdata_in[MSR_CTS_TOG]));
        end
    end

    // Idle counter, receive-side flags and transmit-drained flag
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            idle_cnt <= 8'h00;
            idle_flag <= 1'b0;
            txd_flag <= 1'b1;
            rxl_flag <= 1'b0;
        end else if (clk_en_in) begin
            if (rx_push_in || rd_rbr || rx_empty) idle_cnt <= 8'h00;
            else if (idle_tick_in && idle_cnt != idle_cmp) idle_cnt <= idle_cnt + 8'h01;
            if (!rx_empty && !rx_push_in && !rd_rbr && idle_cnt == idle_cmp && idle_cmp != 8'h00)
                idle_flag <= 1'b1;
            else if (rd_rbr || rx_push_in || rx_empty)
                idle_flag <= 1'b0;
            if (tx_last_shift_in) txd_flag <= 1'b1;
            else if (wr_thr) txd_flag <= 1'b0;
            if (rx_count_in == trig_c) rxl_flag <= 1'b1;
            else if (rx_count_in < trig_c) rxl_flag <= 1'b0;
        end
    end

    // Registered outputs
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            prdata_out <= 32'h0000_0000;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            irq_out <= 1'b0;
            dma_ind_out <= 6'h00;
            rx_pop_out <= 1'b0;
            tx_push_out <= 1'b0;
        end else if (clk_en_in) begin
            pready_out <= psel_in & ~penable_in;
            pslverr_out <= psel_in & ~penable_in & ~mapped;
            prdata_out <= (psel_in & ~penable_in & ~pwrite_in) ? rdata : 32'h0000_0000;
            irq_out <= next_irq;
            dma_ind_out <= next_dma_ind;
            rx_pop_out <= rd_rbr & pready_out;
            tx_push_out <= wr_thr & pready_out & ~tx_full_in;
        end
    end

    // Assertions

    // DMA indicators follow enable AND flag one cycle later
    a_dma_ovr_ind: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        clk_en_in |=> dma_ind_out[5] == $past(dma_mode & ier[IER_OVR] & ovr_flag))
        else $error("dma overrun indicator wrong");
    a_dma_idle_ind: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        clk_en_in |=> dma_ind_out[4] == $past(dma_mode & ier[IER_IDLE] & idle_flag))
        else $error("dma idle indicator wrong");
    a_dma_cts_ind: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        clk_en_in |=> dma_ind_out[3] == $past(dma_mode & ier[IER_CTS] & cts_tog))
        else $error("dma cts indicator wrong");
    a_dma_lerr_ind: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        clk_en_in |=> dma_ind_out[2] == $past(dma_mode & ier[IER_LERR] & lerr_flag))
        else $error("dma line error indicator wrong");
    a_dma_txd_ind: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        clk_en_in |=> dma_ind_out[1] == $past(dma_mode & ier[IER_TXD] & txd_flag))
        else $error("dma drained indicator wrong");
    a_dma_rxl_ind: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        clk_en_in |=> dma_ind_out[0] == $past(dma_mode & ier[IER_RXL] & rxl_flag))
        else $error("dma receive level indicator wrong");
    a_dma_ind_off: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in & ~dma_mode) |=> dma_ind_out == 6'h00)
        else $error("dma indicators active outside dma mode");

    // Software-mode indicators raise the request line
    a_sw_ovr_ind: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in & ier[IER_OVR] & ovr_flag) |=> irq_out)
        else $error("overrun indicator lost");
    a_sw_idle_ind: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in & ier[IER_IDLE] & idle_flag) |=> irq_out)
        else $error("idle indicator lost");
    a_sw_cts_ind: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in & ier[IER_CTS] & cts_flag) |=> irq_out)
        else $error("cts indicator lost");
    a_sw_lerr_ind: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in & ier[IER_LERR] & lerr_flag) |=> irq_out)
        else $error("line error indicator lost");
    a_sw_rxl_ind: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in & ier[IER_RXL] & rxl_flag) |=> irq_out)
        else $error("receive level indicator lost");
    a_sw_txd_ind: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in & ier[IER_TXD] & txd_flag) |=> irq_out)
        else $error("drained indicator lost");
    a_irq_or: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        clk_en_in |=> irq_out == $past(next_irq))
        else $error("interrupt line mismatch");
    a_irq_quiet: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in & ~(ier[IER_OVR] | ier[IER_IDLE] | ier[IER_CTS] | ier[IER_LERR] | ier[IER_TXD] | ier[IER_RXL]))
        |=> !irq_out)
        else $error("interrupt without enable");

    // Source flags: set, hold and clear
    a_ovr_follow: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in & rx_overflow_in) |=> isr[ISR_OVR_FLAG])
        else $error("overrun flag not set");
    a_ovr_hold: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in & ovr_flag & ~wr_fsr) |=> ovr_flag)
        else $error("overrun flag dropped without clear");
    a_tx_over_set: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in & wr_thr & tx_full_in) |=> tx_over)
        else $error("transmit overflow not set");
    a_lerr_set: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in & (break_in | framing_in | parity_in)) |=> lerr_flag)
        else $error("line error flag not set");
    a_lerr_hold: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in & lerr_flag & ~wr) |=> lerr_flag)
        else $error("line error flag dropped without clear");
    a_addr_lerr: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in & rs485_mode & addr_byte_in & ~wr) |=> lerr_flag)
        else $error("address byte did not set line error");
    a_cts_toggle: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in & cts_seen & (cts_q != cts_in)) |=> cts_tog)
        else $error("cts toggle not caught");
    a_cts_clear: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in & wr_msr & pwdata_in[MSR_CTS_TOG] & cts_seen & (cts_q == cts_in)) |=> !cts_flag)
        else $error("cts flag not cleared");
    a_txd_set: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in & tx_last_shift_in) |=> txd_flag)
        else $error("drained flag not set");
    a_txd_clear: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in & wr_thr & ~tx_last_shift_in) |=> !txd_flag)
        else $error("drained flag not cleared");

    // Receive-side flags
    a_rxl_level: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in & rx_count_in == trig_c) |=> rxl_flag)
        else $error("receive level flag not set");
    a_rxl_drop: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in & (rx_count_in < trig_c)) |=> !rxl_flag)
        else $error("receive level flag not cleared");
    a_idle_set: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in & ~rx_empty & ~rx_push_in & ~rd_rbr & (idle_cnt == idle_cmp) & (idle_cmp != 8'h00))
        |=> idle_flag)
        else $error("idle flag not set");
    a_idle_empty: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in & rx_empty) |=> !idle_flag)
        else $error("idle flag set with empty fifo");
    a_idle_clear: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in & rd_rbr) |=> !idle_flag)
        else $error("idle flag not cleared by read");

    // Bus answer, side pulses, reserved bits and clock-enable freeze
    a_ready_setup: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in & psel_in & ~penable_in) |=> pready_out)
        else $error("ready missing in access phase");
    a_ready_pulse: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in & pready_out) |=> !pready_out)
        else $error("ready longer than one cycle");
    a_slverr_unmapped: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in & psel_in & ~penable_in & ~mapped) |=> pslverr_out)
        else $error("unmapped access without error");
    a_slverr_mapped: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in & psel_in & ~penable_in & mapped) |=> !pslverr_out)
        else $error("mapped access with error");
    a_rsvd_zero: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in & psel_in & ~penable_in & ~pwrite_in & (paddr_in == ADDR_ISR))
        |=> (prdata_out & 32'hC3C3_C0C0) == 32'h0000_0000)
        else $error("reserved status bits not zero");
    a_pop_read: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in & rd_rbr & pready_out) |=> rx_pop_out)
        else $error("no pop after buffer read");
    a_tx_push: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in & wr_thr & pready_out & ~tx_full_in) |=> tx_push_out)
        else $error("no push after holding write");
    a_push_full: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in & tx_full_in) |=> !tx_push_out)
        else $error("push into full fifo");
    a_freeze_out: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        !clk_en_in |=> ($stable(irq_out) && $stable(dma_ind_out) && $stable(pready_out) && $stable(prdata_out)))
        else $error("outputs moved while clock enable low");
endmodule

/* File: verification/uis_irq_model.sv */
// Interrupt controller model that counts taken interrupt requests
`timescale 1ns/1ns
module uis_irq_model (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic irq_in,
    output logic [7:0] taken_out
);
    logic irq_prev;
    // Count each rising edge of the request line
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            taken_out <= 8'h00;
            irq_prev <= 1'b0;
        end else begin
            irq_prev <= irq_in;
            if (irq_in && !irq_prev) begin
                taken_out <= taken_out + 8'h01;
            end
        end
    end
endmodule

/* File: verification/tb_top.sv */
// Self-checking bench for the serial port interrupt status block
`timescale 1ns/1ns
module tb_top;
    import uis_pkg::*;
    logic core_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cts = 1'b0, txfull = 1'b0, clken = 1'b1;
    logic [7:0] paddr = 8'h00, ev = 8'h00;
    logic [31:0] pwdata = 32'h0, rdata, prdata;
    logic [6:0] rx_count = 7'h00;
    logic pready, pslverr, irq, rx_pop, tx_push, rerr;
    logic [5:0] dma_ind;
    logic [7:0] taken;
    int num_errors = 0, tests_run = 0, cycles = 0, pops = 0, pushes = 0;
    always #4 core_clk_in = ~core_clk_in;
    uis_core u_uis_core (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .clk_en_in(clken),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .cts_in(cts), .rx_overflow_in(ev[0]), .break_in(ev[1]), .framing_in(ev[2]), .parity_in(ev[3]),
        .addr_byte_in(ev[4]), .tx_full_in(txfull), .tx_last_shift_in(ev[5]), .rx_push_in(ev[6]),
        .rx_count_in(rx_count), .idle_tick_in(ev[7]), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .irq_out(irq), .dma_ind_out(dma_ind), .rx_pop_out(rx_pop), .tx_push_out(tx_push));
    uis_irq_model u_uis_irq_model (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .irq_in(irq),
        .taken_out(taken));
    // Cycle ceiling and pulse counters
    always @(posedge core_clk_in) begin
        cycles++;
        pops += (rx_pop === 1'b1);
        pushes += (tx_push === 1'b1);
        if (cycles == 20000) begin
            num_errors++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_in);
        penable <= 1'b1;
        @(posedge core_clk_in);
        while (pready !== 1'b1) @(posedge core_clk_in);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(what, e, rdata & m);
    endtask
    // One-cycle pulses on the event inputs
    task automatic pulse(input logic [7:0] m);
        @(posedge core_clk_in);
        ev <= m;
        @(posedge core_clk_in);
        ev <= 8'h00;
    endtask
    initial begin
        repeat (6) @(posedge core_clk_in);
        resetn_in <= 1'b1;
        rdchk("isr reset", ADDR_ISR, 32'hFFFFFFFF, 32'h00000002);
        // Overrun from either FIFO
        apb(1'b1, ADDR_IER, 32'h00000020);
        pulse(8'h01);
        rdchk("ovr rx", ADDR_ISR, 32'h00002020, 32'h00002020);
        chk("irq ovr", 32'h1, {31'h0, irq});
        txfull <= 1'b1;
        apb(1'b1, ADDR_THR, 32'h000000A5);
        txfull <= 1'b0;
        rdchk("tx over", ADDR_FSR, 32'h01000000, 32'h01000000);
        apb(1'b1, ADDR_FSR, 32'h00000001);
        rdchk("ovr tx", ADDR_ISR, 32'h00002020, 32'h00002020);
        apb(1'b1, ADDR_FSR, 32'h01000000);
        rdchk("ovr clr", ADDR_ISR, 32'h00002020, 32'h00000000);
        chk("irq taken", 32'h1, {24'h0, taken});
        $display("overrun test done");
        // Line error from each source, cleared only when all are clear
        apb(1'b1, ADDR_IER, 32'h00000004);
        for (int i = 0; i < 3; i++) begin
            pulse(8'h02 << i);
            rdchk("lerr set", ADDR_ISR, 32'h00000404, 32'h00000404);
            apb(1'b1, ADDR_FSR, 32'h00000040 >> i);
            rdchk("lerr clr", ADDR_ISR, 32'h00000404, 32'h00000000);
        end
        pulse(8'h06);
        apb(1'b1, ADDR_FSR, 32'h00000040);
        rdchk("lerr hold", ADDR_ISR, 32'h00000404, 32'h00000404);
        apb(1'b1, ADDR_FSR, 32'h00000020);
        apb(1'b1, ADDR_CFG, 32'h00000102);
        pulse(8'h10);
        rdchk("lerr addr", ADDR_ISR, 32'h00000404, 32'h00000404);
        apb(1'b1, ADDR_FSR, 32'h00000008);
        rdchk("lerr addr clr", ADDR_ISR, 32'h00000404, 32'h00000000);
        apb(1'b1, ADDR_CFG, 32'h00000100);
        $display("line error test done");
        // CTS change and its write-one clear
        apb(1'b1, ADDR_IER, 32'h00000008);
        cts <= 1'b1;
        rdchk("cts tog", ADDR_MSR, 32'h00000001, 32'h00000001);
        rdchk("cts set", ADDR_ISR, 32'h00000808, 32'h00000808);
        apb(1'b1, ADDR_MSR, 32'h00000001);
        rdchk("cts clr", ADDR_ISR, 32'h00000808, 32'h00000000);
        // Transmit drained: holding write clears, last shift sets
        apb(1'b1, ADDR_IER, 32'h00000002);
        pulse(8'h20);
        rdchk("txd set", ADDR_ISR, 32'h00000202, 32'h00000202);
        apb(1'b1, ADDR_THR, 32'h0000005A);
        rdchk("txd clr", ADDR_ISR, 32'h00000202, 32'h00000000);
        chk("tx pushes", 32'h1, pushes);
        pulse(8'h20);
        rdchk("txd again", ADDR_ISR, 32'h00000202, 32'h00000202);
        $display("cts and drained test done");
        // Receive level at trigger two and idle after two ticks
        apb(1'b1, ADDR_CFG, 32'h00000200);
        apb(1'b1, ADDR_TOR, 32'h00000002);
        apb(1'b1, ADDR_IER, 32'h00000011);
        rx_count <= 7'h01;
        pulse(8'h40);
        rdchk("rxl below", ADDR_ISR, 32'h00001111, 32'h00000000);
        rx_count <= 7'h02;
        pulse(8'h40);
        rdchk("rxl set", ADDR_ISR, 32'h00001111, 32'h00000101);
        pulse(8'h80);
        pulse(8'h80);
        rdchk("idle set", ADDR_ISR, 32'h00001111, 32'h00001111);
        apb(1'b0, ADDR_RBR, 32'h0);
        rx_count <= 7'h01;
        rdchk("rx clr", ADDR_ISR, 32'h00001111, 32'h00000000);
        chk("rx pops", 32'h1, pops);
        $display("receive test done");
        // DMA mode indicators, read-only status and unmapped access
        apb(1'b1, ADDR_CFG, 32'h00000101);
        apb(1'b1, ADDR_IER, 32'h000000FF);
        cts <= 1'b0;
        pulse(8'h43);
        pulse(8'h80);
        pulse(8'h80);
        rdchk("dma isr", ADDR_ISR, 32'h3C3C0000, 32'h3C3C0000);
        chk("dma ind", 32'h3F, {26'h0, dma_ind});
        apb(1'b1, ADDR_ISR, 32'hFFFFFFFF);
        rdchk("isr ro", ADDR_ISR, 32'hFFFFC0C0, 32'h3C3C0000);
        apb(1'b0, 8'hF0, 32'h0);
        chk("unmapped", 32'h1, {31'h0, rerr});
        apb(1'b1, ADDR_IER, 32'h00000000);
        rdchk("dma off", ADDR_ISR, 32'h3C000000, 32'h00000000);
        chk("irq off", 32'h0, {31'h0, irq});
        $display("dma test done");
        // Mid-run reset restores reset values; clock enable low freezes the flags
        rx_count <= 7'h00;
        resetn_in <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        resetn_in <= 1'b1;
        rdchk("isr rerun", ADDR_ISR, 32'hFFFFFFFF, 32'h00000002);
        clken <= 1'b0;
        pulse(8'h01);
        clken <= 1'b1;
        rdchk("frozen ovr", ADDR_ISR, 32'h00000020, 32'h00000000);
        $display("reset and freeze test done");
        results();
    end
endmodule
